/* rsc_pkg.sv */
// Constants, cause encoding and state type for the reset source controller.
// Assumes a single 200 MHz system clock shared by every user of the package.
// ============================================================================
// Reset source controller package
package rsc_pkg;

	// ========================================================================
	// Clock and timing
	localparam int CLK_PERIOD_NS = 5;
	// Least time the system reset stays asserted after its cause is gone
	localparam int RESET_HOLD_NS = 1000;
	localparam int RESET_HOLD_CYCLES =
		(RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_CNT_W = 8;
	localparam logic [HOLD_CNT_W-1:0] HOLD_LOAD =
		HOLD_CNT_W'(RESET_HOLD_CYCLES - 1);
	localparam logic [HOLD_CNT_W-1:0] HOLD_CNT_ZERO = 8'h00;

	// ========================================================================
	// Reset cause flags, one bit per source
	localparam int CAUSE_W = 7;
	localparam int CAUSE_EXT = 0;
	localparam int CAUSE_POR = 1;
	localparam int CAUSE_WDG = 2;
	localparam int CAUSE_LOCK = 3;
	localparam int CAUSE_CLK = 4;
	localparam int CAUSE_SOFT = 5;
	localparam int CAUSE_LSD = 6;
	localparam logic [CAUSE_W-1:0] CAUSE_RST = 7'h02;

	// ========================================================================
	// Asynchronous inputs brought through two flip-flops
	localparam int SYNC_W = 4;
	localparam int SYNC_EXT = 0;
	localparam int SYNC_LOCK = 1;
	localparam int SYNC_CLK = 2;
	localparam int SYNC_LSD = 3;
	localparam logic [SYNC_W-1:0] SYNC_RST = 4'h0;

	// ========================================================================
	// Watchdog
	localparam int WDG_W = 32;
	localparam logic [WDG_W-1:0] WDG_COUNT_RST = 32'hffff_ffff;

	// Sequencer states, Gray along run -> hold -> release -> hold; release -> run flips both bits
	typedef enum logic [1:0] {
		RSC_RUN = 2'h0,
		RSC_HOLD = 2'h1,
		RSC_RELEASE = 2'h3
	} rsc_state_t;

endpackage : rsc_pkg

/* rsc_watchdog.sv */
// 32-bit watchdog down-counter, counting only while run is high, with reload and underflow.
// Assumes run, reload and timeout come from logic on clk_sys.
`timescale 1ns/1ps
module rsc_watchdog import rsc_pkg::*; #(
	parameter int WIDTH = WDG_W
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic run,
	input wire logic reload,
	input wire logic [WIDTH-1:0] timeout,
	output logic [WIDTH-1:0] count,
	output logic underflow
);

	// ========================================================================
	// Counter
	logic [WIDTH-1:0] count_r;
	logic [WIDTH-1:0] count_nxt;

	// Underflow when the count has run out while running
	assign underflow = run & ~reload & (count_r == '0);
	assign count = count_r;

	// Next count: reload, wrap to timeout on underflow, else count down
	always_comb begin
		count_nxt = count_r;
		if (reload || underflow) begin
			count_nxt = timeout;
		end else if (run) begin
			count_nxt = count_r - WIDTH'(1);
		end
	end

	// Register
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			count_r <= WDG_COUNT_RST;
		end else if (clk_en) begin
			count_r <= count_nxt;
		end
	end

	// ========================================================================
	// Checks
	property p_wdg_reload;
		@(posedge clk_sys) disable iff (!reset_n)
		clk_en && reload |=> count_r == $past(timeout);
	endproperty
	a_wdg_reload: assert property (p_wdg_reload)
		else $error("watchdog did not reload from timeout");

	property p_wdg_down;
		@(posedge clk_sys) disable iff (!reset_n)
		clk_en && run && !reload && count_r != '0
		|=> count_r == $past(count_r) - WIDTH'(1);
	endproperty
	a_wdg_down: assert property (p_wdg_down)
		else $error("watchdog did not count down by one");

	property p_wdg_under;
		@(posedge clk_sys) disable iff (!reset_n)
		run && !reload && count_r == '0 |-> underflow;
	endproperty
	a_wdg_under: assert property (p_wdg_under)
		else $error("watchdog missed underflow at zero");

endmodule : rsc_watchdog

/* rsc_reset_controller.sv */
// Reset source controller: gathers seven reset sources, holds system reset,
// records the last cause, drives the reset output pin, low supply handling.
// Assumes reset_n is the power-on reset, synchronous to clk_sys; pin and
// analog detector inputs are asynchronous and are synchronised here.
`timescale 1ns/1ps
module rsc_reset_controller import rsc_pkg::*; #(
	parameter int WDG_WIDTH = WDG_W
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic reset_in_pin_n,
	input wire logic pll_lock_lost,
	input wire logic pll_clock_lost,
	input wire logic low_supply_detector_trip,
	input wire logic soft_reset_req,
	input wire logic reset_out_assert,
	input wire logic low_supply_detector_en,
	input wire logic low_supply_detector_reset_sel,
	input wire logic wdg_enable,
	input wire logic wdg_restart,
	input wire logic [WDG_WIDTH-1:0] wdg_timeout,
	output logic sys_reset_n,
	output logic reset_out_pin_n,
	output logic [CAUSE_W-1:0] reset_cause,
	output logic low_supply_irq,
	output logic [WDG_WIDTH-1:0] wdg_count
);

	// ========================================================================
	// Input synchronisers
	logic [SYNC_W-1:0] async_in;
	logic [SYNC_W-1:0] meta_r;
	logic [SYNC_W-1:0] sync_r;

	// Active-high view of the asynchronous inputs
	assign async_in[SYNC_EXT] = ~reset_in_pin_n;
	assign async_in[SYNC_LOCK] = pll_lock_lost;
	assign async_in[SYNC_CLK] = pll_clock_lost;
	assign async_in[SYNC_LSD] = low_supply_detector_trip;

	// Two flip-flops per input, first stage read only by the second
	genvar gi;
	generate
		for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
			always_ff @(posedge clk_sys) begin
				if (!reset_n) begin
					meta_r[gi] <= 1'b0;
					sync_r[gi] <= 1'b0;
				end else if (clk_en) begin
					meta_r[gi] <= async_in[gi];
					sync_r[gi] <= meta_r[gi];
				end
			end
		end
	endgenerate

	// ========================================================================
	// Watchdog
	rsc_state_t state_r;
	rsc_state_t state_nxt;
	logic wdg_run;
	logic wdg_reload;
	logic wdg_underflow;

	// Watchdog runs only outside system reset; reset and restart reload it
	assign wdg_run = wdg_enable & (state_r == RSC_RUN);
	assign wdg_reload = wdg_restart | (state_r != RSC_RUN);

	rsc_watchdog #(
		.WIDTH(WDG_WIDTH)
	) u_watchdog (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.run(wdg_run),
		.reload(wdg_reload),
		.timeout(wdg_timeout),
		.count(wdg_count),
		.underflow(wdg_underflow)
	);

	// ========================================================================
	// Reset sources
	logic [CAUSE_W-1:0] src;
	logic any_src;
	logic lsd_active;

	// Low supply trip while the detector is enabled
	// detector enable gate
	assign lsd_active = sync_r[SYNC_LSD] & low_supply_detector_en;

	always_comb begin
		src = '0;
		src[CAUSE_EXT] = sync_r[SYNC_EXT];
		src[CAUSE_POR] = 1'b0; // Power-on acts through reset_n
		src[CAUSE_WDG] = wdg_underflow;
		src[CAUSE_LOCK] = sync_r[SYNC_LOCK];
		src[CAUSE_CLK] = sync_r[SYNC_CLK];
		src[CAUSE_SOFT] = soft_reset_req;
		src[CAUSE_LSD] = lsd_active & low_supply_detector_reset_sel;
	end
	assign any_src = |src;

	// One-hot pick of the winning source, supply and pin first
	function automatic logic [CAUSE_W-1:0] pick_cause(
		input logic [CAUSE_W-1:0] s
	);
		logic [CAUSE_W-1:0] r;
		r = '0;
		if (s[CAUSE_LSD]) begin
			r[CAUSE_LSD] = 1'b1;
		end else if (s[CAUSE_EXT]) begin
			r[CAUSE_EXT] = 1'b1;
		end else if (s[CAUSE_CLK]) begin
			r[CAUSE_CLK] = 1'b1;
		end else if (s[CAUSE_LOCK]) begin
			r[CAUSE_LOCK] = 1'b1;
		end else if (s[CAUSE_WDG]) begin
			r[CAUSE_WDG] = 1'b1;
		end else if (s[CAUSE_SOFT]) begin
			r[CAUSE_SOFT] = 1'b1;
		end
		return r;
	endfunction : pick_cause

	// ========================================================================
	// Reset sequencer
	logic [HOLD_CNT_W-1:0] hold_cnt_r;
	logic [HOLD_CNT_W-1:0] hold_cnt_nxt;
	logic [CAUSE_W-1:0] cause_r;
	logic [CAUSE_W-1:0] cause_nxt;

	// Next state, hold count and cause
	always_comb begin
		state_nxt = state_r;
		hold_cnt_nxt = hold_cnt_r;
		cause_nxt = cause_r;
		case (state_r)
			RSC_RUN: begin
				if (any_src) begin
					state_nxt = RSC_HOLD;
					hold_cnt_nxt = HOLD_LOAD;
					cause_nxt = pick_cause(src);
				end
			end
			RSC_HOLD: begin
				// A source still active restarts the hold time
				if (any_src) begin
					hold_cnt_nxt = HOLD_LOAD;
				end else if (hold_cnt_r == HOLD_CNT_ZERO) begin
					state_nxt = RSC_RELEASE;
				end else begin
					hold_cnt_nxt = hold_cnt_r - HOLD_CNT_W'(1);
				end
			end
			RSC_RELEASE: begin
				state_nxt = any_src ? RSC_HOLD : RSC_RUN;
				if (any_src) begin
					hold_cnt_nxt = HOLD_LOAD;
					cause_nxt = pick_cause(src);
				end
			end
			default: begin
				state_nxt = RSC_HOLD;
				hold_cnt_nxt = HOLD_LOAD;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			state_r <= RSC_HOLD;
			hold_cnt_r <= HOLD_LOAD;
			cause_r <= CAUSE_RST;
		end else if (clk_en) begin
			state_r <= state_nxt;
			hold_cnt_r <= hold_cnt_nxt;
			cause_r <= cause_nxt;
		end
	end

	// ========================================================================
	// Outputs
	logic sys_reset_n_r;
	logic sys_reset_n_nxt;
	logic reset_out_pin_n_r;
	logic reset_out_pin_n_nxt;
	logic low_supply_irq_r;
	logic low_supply_irq_nxt;

	// Output next values
	always_comb begin
		sys_reset_n_nxt = (state_nxt == RSC_RUN);
		reset_out_pin_n_nxt = ~reset_out_assert & (state_nxt == RSC_RUN);
		low_supply_irq_nxt = lsd_active & ~low_supply_detector_reset_sel;
	end

	// Output registers
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			sys_reset_n_r <= 1'b0;
			reset_out_pin_n_r <= 1'b0;
			low_supply_irq_r <= 1'b0;
		end else if (clk_en) begin
			sys_reset_n_r <= sys_reset_n_nxt;
			reset_out_pin_n_r <= reset_out_pin_n_nxt;
			low_supply_irq_r <= low_supply_irq_nxt;
		end
	end

	assign sys_reset_n = sys_reset_n_r;
	assign reset_out_pin_n = reset_out_pin_n_r;
	assign low_supply_irq = low_supply_irq_r;
	assign reset_cause = cause_r;

	// ========================================================================
	// Checks
	sequence s_src_in_run;
		clk_en && state_r == RSC_RUN && any_src;
	endsequence

	sequence s_enter_hold;
		state_r == RSC_HOLD && !sys_reset_n_r && hold_cnt_r == HOLD_LOAD;
	endsequence

	property p_src_resets;
		@(posedge clk_sys) disable iff (!reset_n)
		s_src_in_run |=> s_enter_hold;
	endproperty
	a_src_resets: assert property (p_src_resets)
		else $error("active source did not assert system reset");

	property p_cause_onehot;
		@(posedge clk_sys) disable iff (!reset_n)
		state_r != RSC_RUN |-> $onehot(cause_r);
	endproperty
	a_cause_onehot: assert property (p_cause_onehot)
		else $error("reset cause is not a single flag");

	property p_wdg_cause;
		@(posedge clk_sys) disable iff (!reset_n)
		s_src_in_run and (src == (7'h01 << CAUSE_WDG))
		|=> reset_cause[CAUSE_WDG];
	endproperty
	a_wdg_cause: assert property (p_wdg_cause)
		else $error("watchdog reset not recorded");

	property p_cause_kept;
		@(posedge clk_sys) disable iff (!reset_n)
		clk_en && state_r == RSC_RUN && !any_src |=> $stable(cause_r);
	endproperty
	a_cause_kept: assert property (p_cause_kept)
		else $error("reset cause changed without a reset");

	property p_pin_sw;
		@(posedge clk_sys) disable iff (!reset_n)
		clk_en && reset_out_assert |=> !reset_out_pin_n;
	endproperty
	a_pin_sw: assert property (p_pin_sw)
		else $error("reset output pin not asserted by control bit");

	property p_lsd_irq;
		@(posedge clk_sys) disable iff (!reset_n)
		clk_en && lsd_active && !low_supply_detector_reset_sel
		|=> low_supply_irq;
	endproperty
	a_lsd_irq: assert property (p_lsd_irq)
		else $error("low supply interrupt missing");

	property p_lsd_gate;
		@(posedge clk_sys) disable iff (!reset_n)
		clk_en && !low_supply_detector_en
		|-> !src[CAUSE_LSD] ##1 !low_supply_irq;
	endproperty
	a_lsd_gate: assert property (p_lsd_gate)
		else $error("disabled low supply detector acted");

	property p_hold_min;
		@(posedge clk_sys) disable iff (!reset_n)
		state_r == RSC_HOLD && !any_src && hold_cnt_r != HOLD_CNT_ZERO
		|-> !sys_reset_n && state_nxt == RSC_HOLD;
	endproperty
	a_hold_min: assert property (p_hold_min)
		else $error("system reset released early");

	property p_sources;
		@(posedge clk_sys) disable iff (!reset_n)
		clk_en && state_r == RSC_RUN && (sync_r[SYNC_EXT] || soft_reset_req
			|| sync_r[SYNC_LOCK] || sync_r[SYNC_CLK]) |=> !sys_reset_n;
	endproperty
	a_sources: assert property (p_sources)
		else $error("reset source ignored");

endmodule : rsc_reset_controller

/* rsc_reset_controller_test.sv */
// Self-checking bench for the reset source controller.
// Assumes the design top rsc_reset_controller and package rsc_pkg.
`timescale 1ns/1ps
module rsc_reset_controller_test import rsc_pkg::*;;
	logic clk_sys, reset_n, clk_en, reset_in_pin_n, pll_lock_lost;
	logic pll_clock_lost, low_supply_detector_trip, soft_reset_req;
	logic reset_out_assert, low_supply_detector_en;
	logic low_supply_detector_reset_sel, wdg_enable, wdg_restart;
	logic [31:0] wdg_timeout, wdg_count;
	logic sys_reset_n, reset_out_pin_n, low_supply_irq;
	logic [CAUSE_W-1:0] reset_cause;
	int n_errors = 0;
	int checks_done = 0;
	int cycles = 0;
	int prio[$] = '{CAUSE_LSD, CAUSE_EXT, CAUSE_CLK, CAUSE_LOCK, CAUSE_WDG,
		CAUSE_SOFT};
	int t;

	rsc_reset_controller dut (.clk_sys(clk_sys), .reset_n(reset_n),
		.clk_en(clk_en), .reset_in_pin_n(reset_in_pin_n),
		.pll_lock_lost(pll_lock_lost), .pll_clock_lost(pll_clock_lost),
		.low_supply_detector_trip(low_supply_detector_trip),
		.soft_reset_req(soft_reset_req), .reset_out_assert(reset_out_assert),
		.low_supply_detector_en(low_supply_detector_en),
		.low_supply_detector_reset_sel(low_supply_detector_reset_sel),
		.wdg_enable(wdg_enable), .wdg_restart(wdg_restart),
		.wdg_timeout(wdg_timeout), .sys_reset_n(sys_reset_n),
		.reset_out_pin_n(reset_out_pin_n), .reset_cause(reset_cause),
		.low_supply_irq(low_supply_irq), .wdg_count(wdg_count));

	// ========================================================================
	// Clock, timeout, verdict
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			end_of_test();
		end
	end
	task end_of_test();
		$display("errors=%0d checks=%0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_of_test

	// ========================================================================
	// Compare tasks and cause model
	task chk_bit(input logic g, input logic e);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch t=%0t got=%0h exp=%0h", $time, g, e);
		end
	endtask : chk_bit
	task chk_vec(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch t=%0t got=%0h exp=%0h", $time, g, e);
		end
	endtask : chk_vec
	function automatic logic [31:0] cause_of(input int m);
		foreach (prio[i])
			if (m[prio[i]])
				return 32'h1 << prio[i];
		return 32'h0;
	endfunction : cause_of

	// ========================================================================
	// Stimulus helpers
	task idle_src();
		reset_in_pin_n <= 1'b1;
		pll_lock_lost <= 1'b0;
		pll_clock_lost <= 1'b0;
		low_supply_detector_trip <= 1'b0;
		soft_reset_req <= 1'b0;
		wdg_restart <= 1'b0;
		wdg_enable <= 1'b0;
	endtask : idle_src
	task por();
		int k;
		@(posedge clk_sys);
		reset_n <= 1'b0;
		repeat (4) @(posedge clk_sys);
		#1;
		chk_bit(sys_reset_n, 1'b0);
		chk_vec(wdg_count, WDG_COUNT_RST);
		@(posedge clk_sys);
		reset_n <= 1'b1;
		k = 0;
		while (sys_reset_n !== 1'b1 && k < 400) begin
			@(posedge clk_sys);
			#1;
			k++;
		end
		chk_vec(k, RESET_HOLD_CYCLES + 1);
		chk_vec(reset_cause, CAUSE_RST);
	endtask : por
	// Wait for a reset, check latency, cause and hold length
	task wait_rst(input int lat, input int m);
		int n;
		int k;
		n = 0;
		while (sys_reset_n !== 1'b0 && n < 20) begin
			@(posedge clk_sys);
			idle_src();
			#1;
			n++;
		end
		chk_vec(n, lat);
		chk_vec(reset_cause, cause_of(m));
		chk_bit(reset_out_pin_n, 1'b0);
		k = 0;
		while (sys_reset_n !== 1'b1 && k < 400) begin
			@(posedge clk_sys);
			#1;
			k++;
		end
		chk_vec(k, RESET_HOLD_CYCLES + 1);
		chk_bit(reset_out_pin_n, 1'b1);
	endtask : wait_rst
	task fire(input int m, input int lat);
		@(posedge clk_sys);
		reset_in_pin_n <= !m[CAUSE_EXT];
		pll_lock_lost <= m[CAUSE_LOCK];
		pll_clock_lost <= m[CAUSE_CLK];
		low_supply_detector_trip <= m[CAUSE_LSD];
		soft_reset_req <= m[CAUSE_SOFT];
		wait_rst(lat, m);
	endtask : fire
	task restart(input int tmo);
		@(posedge clk_sys);
		wdg_timeout <= tmo;
		wdg_enable <= 1'b1;
		wdg_restart <= 1'b1;
		@(posedge clk_sys);
		wdg_restart <= 1'b0;
		#1;
		chk_vec(wdg_count, tmo);
	endtask : restart

	// ========================================================================
	// Main sequence
	initial begin
		reset_n = 1'b0;
		clk_en = 1'b1;
		reset_in_pin_n = 1'b1;
		pll_lock_lost = 1'b0;
		pll_clock_lost = 1'b0;
		low_supply_detector_trip = 1'b0;
		soft_reset_req = 1'b0;
		reset_out_assert = 1'b0;
		low_supply_detector_en = 1'b1;
		low_supply_detector_reset_sel = 1'b1;
		wdg_enable = 1'b0;
		wdg_restart = 1'b0;
		wdg_timeout = 32'h0000_0010;
		void'($urandom(32'hb9547d31));
		por();
		// each source but watchdog and power-on alone, then mixes by priority
		fire(1 << CAUSE_SOFT, 1);
		foreach (prio[i])
			if (prio[i] != CAUSE_WDG && prio[i] != CAUSE_SOFT)
				fire(1 << prio[i], 3);
		fire((1 << CAUSE_LOCK) | (1 << CAUSE_CLK), 3);
		fire(32'h5b, 3);
		// underflow of a random short timeout
		t = $urandom_range(12, 2);
		restart(t);
		for (int i = 1; i <= t; i++) begin
			@(posedge clk_sys);
			#1;
			chk_vec(wdg_count, t - i);
		end
		wait_rst(1, 1 << CAUSE_WDG);
		// periodic restarts hold off the reset
		for (int i = 0; i < 10; i++)
			restart(5);
		chk_bit(sys_reset_n, 1'b1);
		// Clock enable low freezes the count one below the reload of 5
		@(posedge clk_sys);
		clk_en <= 1'b0;
		repeat (4) @(posedge clk_sys);
		#1;
		chk_vec(wdg_count, 32'h4);
		@(posedge clk_sys);
		clk_en <= 1'b1;
		wdg_enable <= 1'b0;
		@(posedge clk_sys);
		reset_out_assert <= 1'b1;
		@(posedge clk_sys);
		#1;
		chk_bit(reset_out_pin_n, 1'b0);
		chk_bit(sys_reset_n, 1'b1);
		@(posedge clk_sys);
		reset_out_assert <= 1'b0;
		@(posedge clk_sys);
		#1;
		chk_bit(reset_out_pin_n, 1'b1);
		// low supply as interrupt, then disabled
		@(posedge clk_sys);
		low_supply_detector_reset_sel <= 1'b0;
		low_supply_detector_trip <= 1'b1;
		repeat (3) @(posedge clk_sys);
		#1;
		chk_bit(low_supply_irq, 1'b1);
		chk_bit(sys_reset_n, 1'b1);
		@(posedge clk_sys);
		low_supply_detector_en <= 1'b0;
		repeat (3) @(posedge clk_sys);
		#1;
		chk_bit(low_supply_irq, 1'b0);
		chk_bit(sys_reset_n, 1'b1);
		@(posedge clk_sys);
		low_supply_detector_trip <= 1'b0;
		// Let the synchronised trip clear before re-enabling
		repeat (2) @(posedge clk_sys);
		low_supply_detector_en <= 1'b1;
		low_supply_detector_reset_sel <= 1'b1;
		// Second power-on reset mid-run replaces the cause
		por();
		end_of_test();
	end
endmodule : rsc_reset_controller_test
